// ---- ctp_pkg.sv ----
// Package for the cascaded 12-bit pulse-width timer
package ctp_pkg;
  // Register byte offsets
  localparam logic [7:0] ADDR_DUTY_LO = 8'h00;
  localparam logic [7:0] ADDR_DUTY_HI = 8'h04;
  localparam logic [7:0] ADDR_MODE    = 8'h08;
  localparam logic [7:0] ADDR_RUN     = 8'h0c;
  localparam logic [7:0] ADDR_STATUS  = 8'h10;
  localparam logic [7:0] ADDR_COUNT   = 8'h14;
  // Mode register fields
  localparam int MODE_LEVEL_BIT   = 0;
  localparam int MODE_BUFFER_BIT  = 1;
  localparam int MODE_EXTCLK_BIT  = 2;
  localparam int MODE_CASCADE_BIT = 3;
  localparam int MODE_FIELD_LSB   = 4;
  localparam logic [1:0] MODE_PWM12 = 2'h2;
  // Run register field
  localparam int RUN_BIT = 0;
  // Status register fields (write one to clear)
  localparam int STAT_OVF_BIT   = 0;
  localparam int STAT_FRAME_BIT = 1;
  // Reset values
  localparam logic [7:0] DUTY_LO_RST = 8'hff;
  localparam logic [7:0] DUTY_HI_RST = 8'hff;
  localparam logic [7:0] MODE_RST    = 8'h00;
  localparam logic [7:0] PRESCALE_RST = 8'h01;
  // AXI responses
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  // Stretch frame position
  localparam logic [3:0] FRAME_LAST = 4'hf;

  typedef enum logic [2:0] {
    CTP_IDLE = 3'h1,
    CTP_RUN  = 3'h2,
    CTP_STOP = 3'h4
  } ctp_state_t;

  typedef struct packed {
    logic [7:0]  awaddr;
    logic        awvalid;
    logic [31:0] wdata;
    logic [3:0]  wstrb;
    logic        wvalid;
    logic        bready;
    logic [7:0]  araddr;
    logic        arvalid;
    logic        rready;
  } ctp_axi_req_t;

  typedef struct packed {
    logic        awready;
    logic        wready;
    logic [1:0]  bresp;
    logic        bvalid;
    logic        arready;
    logic [31:0] rdata;
    logic [1:0]  rresp;
    logic        rvalid;
  } ctp_axi_rsp_t;

  typedef struct packed {
    ctp_state_t  state;
    ctp_axi_rsp_t axi;
    logic        aw_held;
    logic [7:0]  aw_addr;
    logic        w_held;
    logic [31:0] w_data;
    logic [3:0]  w_strb;
    logic [7:0]  duty_lo_wr;
    logic [7:0]  duty_hi_wr;
    logic [11:0] buf_val;
    logic [11:0] active;
    logic [7:0]  mode;
    logic        run;
    logic [7:0]  prescale;
    logic [7:0]  pre_cnt;
    logic [7:0]  count;
    logic [3:0]  frame;
    logic        toggled;
    logic        pin;
    logic        ovf_flag;
    logic        frame_flag;
    logic        ovf_irq;
    logic        frame_irq;
    logic [1:0]  ext_sync;
    logic        ext_prev;
  } ctp_state_s_t;
endpackage

// ---- ctp_pwm12.sv ----
// Cascaded timer pair in 12-bit pulse-width mode with AXI4-Lite registers
//
// The implementer's own choices: the address map and the AXI4-Lite slave port.
`timescale 1ns/1ns
// What this block does
// RULE1 - Level select bit 0 idles the pulse output low, 1 idles it high.
// RULE2 - While stopped, the pin shows the level select bit.
// RULE3 - Idle before start, active after duty match, idle after overflow and stop.
// RULE4 - Run bit at 1 advances the counter once per source-clock tick.
// RULE5 - Counter low byte equal to duty toggles output away from idle.
// RULE6 - Masked periods delay the toggle to duty plus one count.
// RULE7 - Mask bits pick periods 9; 5,13; 3,7,11,15; and all even periods.
// RULE8 - A zero mask stretches no period.
// RULE9 - At 256 the counter wraps to zero, output returns to idle.
// RULE10 - Every overflow raises the overflow interrupt request.
// RULE11 - Every sixteenth overflow raises the frame interrupt request.
// RULE12 - Clearing run stops and clears the counter, output returns idle.
// RULE13 - External clock stays below half the core rate, phases two cycles.
// RULE14 - Buffer enable bit 0 disables, 1 enables the duty double buffer.
// RULE15 - Buffered running writes load the active value at frame end.
// RULE16 - Buffered duty reads return the last written buffer value.
// RULE17 - Stopped duty writes update buffer and active value together.
// RULE18 - Unbuffered running writes take effect at once.
// RULE19 - New duty below count waits for the next period.
// RULE20 - New duty equal to count matches right after the write.
// RULE21 - Low duty register first; high register write commits all twelve bits.
// RULE22 - High register low nibble holds bits 11..8; low holds duty and mask.
// RULE23 - Software selects cascade and mode 10 before start; running mode writes ignored.
// RULE24 - External pin is synchronised, one count pulse per falling edge.
module ctp_pwm12 (
  input  wire logic                  I_CORE_CLK,
  input  wire logic                  I_RST_B,
  input  wire logic                  I_CE,
  input  wire logic                  I_EXT_CLK,
  input  wire ctp_pkg::ctp_axi_req_t I_AXI,
  output ctp_pkg::ctp_axi_rsp_t      O_AXI,
  output logic                       O_PULSE_OUT,
  output logic                       O_OVERFLOW_IRQ,
  output logic                       O_FRAME_IRQ
);
  ctp_pkg::ctp_state_s_t s_q;
  ctp_pkg::ctp_state_s_t s_d;

  // Mask bit selecting a stretch for 1-based frame period p = idx+1
  function automatic logic stretched(input logic [3:0] mask, input logic [3:0] idx);
    logic [4:0] p;
    p = {1'b0, idx} + 5'h01;
    if (p[0] == 1'b0) stretched = mask[3];  // RULE7
    else if (p[1:0] == 2'h3) stretched = mask[2];
    else if (p == 5'h05 || p == 5'h0d) stretched = mask[1];
    else if (p == 5'h09) stretched = mask[0];
    else stretched = 1'b0;  // RULE8
  endfunction

  function automatic logic [31:0] read_mux(input ctp_pkg::ctp_state_s_t s, input logic [7:0] a);
    read_mux = 32'h0;
    case (a)
      ctp_pkg::ADDR_DUTY_LO: read_mux = {24'h0, s.duty_lo_wr};  // RULE16
      ctp_pkg::ADDR_DUTY_HI: read_mux = {24'h0, s.duty_hi_wr};
      ctp_pkg::ADDR_MODE:    read_mux = {24'h0, s.mode};
      ctp_pkg::ADDR_RUN:     read_mux = {16'h0, s.prescale, 7'h0, s.run};
      ctp_pkg::ADDR_STATUS:  read_mux = {30'h0, s.frame_flag, s.ovf_flag};
      ctp_pkg::ADDR_COUNT:   read_mux = {20'h0, s.frame, s.count};
      default:               read_mux = 32'h0;
    endcase
  endfunction

  function automatic logic known(input logic [7:0] a);
    known = (a == ctp_pkg::ADDR_DUTY_LO) || (a == ctp_pkg::ADDR_DUTY_HI) ||
            (a == ctp_pkg::ADDR_MODE) || (a == ctp_pkg::ADDR_RUN) ||
            (a == ctp_pkg::ADDR_STATUS) || (a == ctp_pkg::ADDR_COUNT);
  endfunction

  always_comb begin
    logic        tick;
    logic        wr_go;
    logic        ext_fall;
    logic        level;
    logic [7:0]  target;
    logic [11:0] commit;
    logic        commit_now;
    logic        ovf;
    logic [31:0] wd;
    logic [7:0]  cnt_n;
    s_d = s_q;
    tick = 1'b0;
    ext_fall = 1'b0;
    target = 8'h0;
    cnt_n = s_q.count;
    wr_go = 1'b0;
    commit_now = 1'b0;
    ovf = 1'b0;
    level = s_q.mode[ctp_pkg::MODE_LEVEL_BIT];
    wd = s_q.w_data;
    commit = s_q.buf_val;
    s_d.ovf_irq = 1'b0;
    s_d.frame_irq = 1'b0;

    // External pin: two-stage sync, then edge detect on the second stage
    s_d.ext_sync = {s_q.ext_sync[0], I_EXT_CLK};
    s_d.ext_prev = s_q.ext_sync[1];
    ext_fall = s_q.ext_prev & ~s_q.ext_sync[1];  // RULE24

    // Source tick: external edge or internal divide by prescale
    if (s_q.mode[ctp_pkg::MODE_EXTCLK_BIT]) begin
      tick = ext_fall;
      s_d.pre_cnt = 8'h0;
    end else if (s_q.run) begin
      if (s_q.pre_cnt >= s_q.prescale - 8'h01) begin
        s_d.pre_cnt = 8'h0;
        tick = 1'b1;
      end else begin
        s_d.pre_cnt = s_q.pre_cnt + 8'h01;
      end
    end

    // AXI write channels, taken in either order
    if (s_q.axi.awready && I_AXI.awvalid) begin
      s_d.aw_held = 1'b1;
      s_d.aw_addr = I_AXI.awaddr;
      s_d.axi.awready = 1'b0;
    end
    if (s_q.axi.wready && I_AXI.wvalid) begin
      s_d.w_held = 1'b1;
      s_d.w_data = I_AXI.wdata;
      s_d.w_strb = I_AXI.wstrb;
      s_d.axi.wready = 1'b0;
    end
    if (s_q.aw_held && s_q.w_held && !s_q.axi.bvalid) begin
      wr_go = s_q.w_strb[0];
      s_d.axi.bvalid = 1'b1;
      s_d.axi.bresp = known(s_q.aw_addr) ? ctp_pkg::RESP_OKAY : ctp_pkg::RESP_SLVERR;
      s_d.aw_held = 1'b0;
      s_d.w_held = 1'b0;
    end
    if (s_q.axi.bvalid && I_AXI.bready) begin
      s_d.axi.bvalid = 1'b0;
      s_d.axi.awready = 1'b1;
      s_d.axi.wready = 1'b1;
    end

    // AXI read channel
    if (s_q.axi.arready && I_AXI.arvalid) begin
      s_d.axi.arready = 1'b0;
      s_d.axi.rvalid = 1'b1;
      s_d.axi.rdata = read_mux(s_q, I_AXI.araddr);
      s_d.axi.rresp = known(I_AXI.araddr) ? ctp_pkg::RESP_OKAY : ctp_pkg::RESP_SLVERR;
    end else if (s_q.axi.rvalid && I_AXI.rready) begin
      s_d.axi.rvalid = 1'b0;
      s_d.axi.arready = 1'b1;
    end

    // Register writes
    if (wr_go) begin
      case (s_q.aw_addr)
        ctp_pkg::ADDR_DUTY_LO: s_d.duty_lo_wr = wd[7:0];
        ctp_pkg::ADDR_DUTY_HI: begin
          s_d.duty_hi_wr = wd[7:0];
          s_d.buf_val = {wd[3:0], s_q.duty_lo_wr};  // RULE21 RULE22
          commit = {wd[3:0], s_q.duty_lo_wr};
          // Stopped or unbuffered: active at once
          commit_now = !s_q.run || !s_q.mode[ctp_pkg::MODE_BUFFER_BIT];  // RULE14 RULE17 RULE18
        end
        ctp_pkg::ADDR_MODE: if (!s_q.run) s_d.mode = wd[7:0];  // RULE23
        ctp_pkg::ADDR_RUN: begin
          s_d.run = wd[ctp_pkg::RUN_BIT];  // RULE4
          if (!s_q.run && wd[15:8] != 8'h0) s_d.prescale = wd[15:8];
        end
        ctp_pkg::ADDR_STATUS: begin
          if (wd[ctp_pkg::STAT_OVF_BIT]) s_d.ovf_flag = 1'b0;
          if (wd[ctp_pkg::STAT_FRAME_BIT]) s_d.frame_flag = 1'b0;
        end
        default: ;
      endcase
    end
    if (commit_now) s_d.active = commit;

    // Duty match target, one later in stretched periods
    target = s_q.active[11:4] + {7'h0, stretched(s_q.active[3:0], s_q.frame)};  // RULE6

    case (s_q.state)
      ctp_pkg::CTP_IDLE: begin
        s_d.pin = level;  // RULE1 RULE2
        s_d.count = 8'h0;
        s_d.frame = 4'h0;
        s_d.toggled = 1'b0;
        if (s_q.run) s_d.state = ctp_pkg::CTP_RUN;
      end
      ctp_pkg::CTP_RUN: begin
        if (!s_q.run) begin
          s_d.state = ctp_pkg::CTP_STOP;
        end else begin
          if (tick) begin
            cnt_n = s_q.count + 8'h01;
            s_d.count = cnt_n;  // RULE4
            ovf = (s_q.count == 8'hff);
          end
          // Immediate compare covers writes equal to the count
          if (ovf) begin
            s_d.pin = level;  // RULE3 RULE9
            s_d.toggled = 1'b0;
            s_d.ovf_irq = 1'b1;  // RULE10
            s_d.ovf_flag = 1'b1;
            s_d.frame = s_q.frame + 4'h1;
            if (s_q.frame == ctp_pkg::FRAME_LAST) begin
              s_d.frame_irq = 1'b1;  // RULE11
              s_d.frame_flag = 1'b1;
              if (s_q.mode[ctp_pkg::MODE_BUFFER_BIT]) s_d.active = s_q.buf_val;  // RULE15
            end
          end else if (!s_q.toggled && (cnt_n == target || s_q.count == target)) begin
            // Pin moves with the count; an equal write still matches at once
            s_d.pin = ~level;  // RULE3 RULE5 RULE19 RULE20
            s_d.toggled = 1'b1;
          end
        end
      end
      ctp_pkg::CTP_STOP: begin
        s_d.count = 8'h0;  // RULE12
        s_d.pin = level;
        s_d.state = ctp_pkg::CTP_IDLE;
      end
      default: s_d.state = ctp_pkg::CTP_IDLE;
    endcase
  end

  always_ff @(posedge I_CORE_CLK or negedge I_RST_B) begin
    if (!I_RST_B) begin
      s_q <= '0;
      s_q.state <= ctp_pkg::CTP_IDLE;
      s_q.axi.awready <= 1'b1;
      s_q.axi.wready <= 1'b1;
      s_q.axi.arready <= 1'b1;
      s_q.duty_lo_wr <= ctp_pkg::DUTY_LO_RST;
      s_q.duty_hi_wr <= ctp_pkg::DUTY_HI_RST;
      s_q.buf_val <= {ctp_pkg::DUTY_HI_RST[3:0], ctp_pkg::DUTY_LO_RST};
      s_q.active <= {ctp_pkg::DUTY_HI_RST[3:0], ctp_pkg::DUTY_LO_RST};
      s_q.mode <= ctp_pkg::MODE_RST;
      s_q.prescale <= ctp_pkg::PRESCALE_RST;
    end else if (I_CE) begin
      s_q <= s_d;
    end
  end

  assign O_AXI = s_q.axi;
  assign O_PULSE_OUT = s_q.pin;
  assign O_OVERFLOW_IRQ = s_q.ovf_irq;
  assign O_FRAME_IRQ = s_q.frame_irq;
endmodule // ctp_pwm12

// ---- ctp_pwm12_chk.sv ----
// Port assertions for the 12-bit pulse-width timer
`timescale 1ns/1ns
module ctp_pwm12_chk (
  input wire logic                  I_CORE_CLK,
  input wire logic                  I_RST_B,
  input wire ctp_pkg::ctp_axi_req_t I_AXI,
  input wire ctp_pkg::ctp_axi_rsp_t O_AXI,
  input wire logic                  O_PULSE_OUT,
  input wire logic                  O_OVERFLOW_IRQ,
  input wire logic                  O_FRAME_IRQ
);
  default clocking @(posedge I_CORE_CLK); endclocking
  default disable iff (!I_RST_B);
  // A period spans 256 ticks, so pulses are far apart
  ovf_gap_a: assert property (O_OVERFLOW_IRQ |=> !O_OVERFLOW_IRQ [*8])
    else $error("overflow too soon");
  frame_ovf_a: assert property (O_FRAME_IRQ |-> O_OVERFLOW_IRQ)
    else $error("frame without overflow");
  frame_gap_a: assert property (O_FRAME_IRQ |=> !O_FRAME_IRQ [*8])
    else $error("frame too soon");
  ovf_idle_a: assert property ($rose(O_OVERFLOW_IRQ) |-> $changed(O_PULSE_OUT))
    else $error("pin kept at overflow");
  wr_take_a: assert property (I_AXI.awvalid && O_AXI.awready && I_AXI.wvalid && O_AXI.wready
    |=> !O_AXI.awready ##1 O_AXI.bvalid) else $error("write answer late");
  b_done_a: assert property (O_AXI.bvalid && I_AXI.bready |=> !O_AXI.bvalid && O_AXI.awready)
    else $error("write answer stuck");
  rd_take_a: assert property (I_AXI.arvalid && O_AXI.arready |=> O_AXI.rvalid && !O_AXI.arready)
    else $error("read answer late");
  r_done_a: assert property (O_AXI.rvalid && I_AXI.rready |=> !O_AXI.rvalid && O_AXI.arready)
    else $error("read answer stuck");
endmodule // ctp_pwm12_chk

bind ctp_pwm12 ctp_pwm12_chk i_chk (.I_CORE_CLK(I_CORE_CLK), .I_RST_B(I_RST_B), .I_AXI(I_AXI),
  .O_AXI(O_AXI), .O_PULSE_OUT(O_PULSE_OUT), .O_OVERFLOW_IRQ(O_OVERFLOW_IRQ),
  .O_FRAME_IRQ(O_FRAME_IRQ));

// ---- ctp_pwm12_test.sv ----
// Self-checking bench for the 12-bit pulse-width timer
`timescale 1ns/1ns
module ctp_pwm12_test;
  logic                  clk = 1'b0;
  logic                  rst_b = 1'b0;
  ctp_pkg::ctp_axi_req_t req = '0;
  ctp_pkg::ctp_axi_rsp_t rsp;
  logic                  pulse;
  logic                  ovf;
  logic                  frm;
  logic                  fw;
  logic                  ext_clk = 1'b0;
  logic [31:0]           d;
  logic [1:0]            r;
  int                    idle;
  int                    bad_count = 0;
  int                    total_checks = 0;
  always #10 clk = ~clk;
  ctp_pwm12 i_dut (.I_CORE_CLK(clk), .I_RST_B(rst_b), .I_CE(1'b1), .I_EXT_CLK(ext_clk),
    .I_AXI(req), .O_AXI(rsp), .O_PULSE_OUT(pulse), .O_OVERFLOW_IRQ(ovf), .O_FRAME_IRQ(frm));
  function automatic logic st(input logic [3:0] m, input int p);
    return (m[0] && p == 9) || (m[1] && p % 8 == 5) || (m[2] && p % 4 == 3) || (m[3] && p % 2 == 0);
  endfunction
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] s);
    total_checks++;
    if (s !== e) begin
      bad_count++;
      $display("[ERR] %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    logic aw, w, b;
    @(posedge clk);
    req.awaddr <= a;
    req.wdata <= v;
    req.awvalid <= 1'b1;
    req.wvalid <= 1'b1;
    b = 1'b0;
    for (int i = 0; i < 40 && !b; i++) begin
      #1;
      aw = req.awvalid & rsp.awready;
      w = req.wvalid & rsp.wready;
      b = rsp.bvalid;
      @(posedge clk);
      if (aw) req.awvalid <= 1'b0;
      if (w) req.wvalid <= 1'b0;
    end
  endtask
  task automatic rd(input logic [7:0] a);
    logic ar, v;
    @(posedge clk);
    req.araddr <= a;
    req.arvalid <= 1'b1;
    v = 1'b0;
    for (int i = 0; i < 40 && !v; i++) begin
      #1;
      ar = req.arvalid & rsp.arready;
      v = rsp.rvalid;
      d = rsp.rdata;
      r = rsp.rresp;
      @(posedge clk);
      if (ar) req.arvalid <= 1'b0;
    end
  endtask
  // Window of one period starts at the overflow pulse
  task automatic per(input logic lvl);
    int k;
    k = 0;
    #1;
    while (ovf !== 1'b1 && k < 600) begin
      @(posedge clk);
      #1;
      k++;
    end
    fw = frm;
    idle = 0;
    repeat (256) begin
      if (pulse === lvl) idle++;
      @(posedge clk);
      #1;
    end
  endtask
  task automatic run_sync(input logic lvl);
    wr(ctp_pkg::ADDR_RUN, 32'h0000_0101);
    fw = 1'b0;
    for (int i = 0; i < 20 && !fw; i++) per(lvl);
  endtask
  task automatic stop(input logic lvl);
    wr(ctp_pkg::ADDR_RUN, 32'h0000_0100);
    repeat (3) @(posedge clk);
    #1;
    chk("stopped pin", 32'(lvl), 32'(pulse));
    rd(ctp_pkg::ADDR_COUNT);
    chk("stopped count", 32'h0, {24'h0, d[7:0]});
  endtask
  task automatic frame(input logic lvl, input logic [3:0] m, input logic [7:0] du);
    wr(ctp_pkg::ADDR_MODE, {24'h0, 4'h2, 3'h4, lvl});
    wr(ctp_pkg::ADDR_DUTY_LO, {24'h0, du[3:0], m});
    wr(ctp_pkg::ADDR_DUTY_HI, {28'h0, du[7:4]});
    #1;
    chk("idle pin", 32'(lvl), 32'(pulse));
    run_sync(lvl);
    for (int p = 1; p <= 16; p++) begin
      if (p > 1) per(lvl);
      chk("idle span", 32'(du) + 32'(st(m, p)), idle);
      chk("frame irq", 32'(p == 1), 32'(fw));
    end
    stop(lvl);
  endtask
  task automatic dbuf(input logic b);
    wr(ctp_pkg::ADDR_MODE, {24'h0, 4'h2, 1'b1, 1'b0, b, 1'b0});
    wr(ctp_pkg::ADDR_DUTY_LO, 32'h0);
    wr(ctp_pkg::ADDR_DUTY_HI, 32'h4);
    run_sync(1'b0);
    wr(ctp_pkg::ADDR_DUTY_LO, 32'h30);
    wr(ctp_pkg::ADDR_DUTY_HI, 32'h9);
    rd(ctp_pkg::ADDR_DUTY_LO);
    chk("duty readback", 32'h30, {24'h0, d[7:0]});
    per(1'b0);
    for (int i = 0; i < 20 && b && !fw; i++) begin
      chk("old duty", 32'h40, idle);
      per(1'b0);
    end
    chk("new duty", 32'h93, idle);
    stop(1'b0);
  endtask
  // Pin high phases of three and low phases of four core cycles keep within the input limits
  task automatic ext_count;
    wr(ctp_pkg::ADDR_MODE, 32'h0000_002c);
    wr(ctp_pkg::ADDR_RUN, 32'h0000_0101);
    repeat (10) begin
      @(posedge clk);
      ext_clk <= 1'b1;
      repeat (3) @(posedge clk);
      ext_clk <= 1'b0;
      repeat (3) @(posedge clk);
    end
    repeat (4) @(posedge clk);
    rd(ctp_pkg::ADDR_COUNT);
    chk("external count", 32'd10, {24'h0, d[7:0]});
    stop(1'b0);
  endtask
  task automatic finish_test;
    $display("checks %0d mismatches %0d", total_checks, bad_count);
    if (bad_count == 0 && total_checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  initial begin
    req.bready = 1'b1;
    req.rready = 1'b1;
    req.wstrb = 4'hf;
    repeat (8) @(posedge clk);
    rst_b <= 1'b1;
    rd(ctp_pkg::ADDR_DUTY_LO);
    chk("duty reset", 32'hff, {24'h0, d[7:0]});
    rd(8'h20);
    chk("unmapped resp", 32'(ctp_pkg::RESP_SLVERR), 32'(r));
    #1;
    chk("reset pin", 32'h0, 32'(pulse));
    for (int i = 0; i < 5; i++) frame(i[0], (i == 0) ? 4'h0 : 4'(1 << (i - 1)), 8'(8'h30 + i));
    dbuf(1'b0);
    dbuf(1'b1);
    ext_count;
    finish_test;
  end
  // Run needs about 55k cycles
  initial begin
    #2_000_000;
    bad_count++;
    finish_test;
  end
endmodule // ctp_pwm12_test
